// *** bench/ibcr_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// APB host issuing register transfers to the bias bank
module ibcr_host_model (
  // Clock
  input wire logic sys_clk_i,
  // APB request
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [ibcr_pkg::IBCR_ADDR_W-1:0] paddr_o,
  output logic [ibcr_pkg::IBCR_DATA_W-1:0] pwdata_o,
  output logic [ibcr_pkg::IBCR_STRB_W-1:0] pstrb_o,
  // APB answer
  input wire logic [ibcr_pkg::IBCR_DATA_W-1:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  import ibcr_pkg::*;

  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
    pstrb_o = '0;
  end

  // One transfer, held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge sys_clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= s;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule // ibcr_host_model

`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import ibcr_pkg::*;
  logic sys_clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic [IBCR_ADDR_W-1:0] paddr;
  logic [IBCR_DATA_W-1:0] pwdata, prdata, rdat;
  logic [IBCR_STRB_W-1:0] pstrb;
  logic fl_ld, az_we, upd, cvalid, rerr;
  logic [IBCR_NUM_WORDS*IBCR_WORD_W-1:0] fl_data, fl_img;
  logic [IBCR_WORD_W-1:0] az_hi;
  logic [IBCR_OFS_W-1:0] raw [4];
  logic [IBCR_OFS_W-1:0] corr [4];
  int mismatches, checks;

  // ==========================================================
  // Design, host and clock
  ibcr_bias_regs #(.STALE_UPDATES(2)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .flash_load_i(fl_ld), .flash_load_data_i(fl_data), .flash_image_o(fl_img),
    .accel_z_bias_high_word_i(az_hi), .accel_z_bias_high_we_i(az_we),
    .sample_update_i(upd), .gyro_z_raw_i(raw[0]), .accel_x_raw_i(raw[1]),
    .accel_y_raw_i(raw[2]), .accel_z_raw_i(raw[3]), .gyro_z_corr_o(corr[0]),
    .accel_x_corr_o(corr[1]), .accel_y_corr_o(corr[2]), .accel_z_corr_o(corr[3]),
    .corr_valid_o(cvalid));
  ibcr_host_model i_host (
    .sys_clk_i(sys_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] pat(input int i);
    return 16'(32'h8001 + 32'h1111 * i);
  endfunction
  function automatic logic [11:0] adr(input int i);
    return 12'(32'h120 + 8 * i);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    i_host.xfer(1'b1, a, {16'h0000, d}, s, rdat, rerr);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic err);
    i_host.xfer(1'b0, a, 32'h0000_0000, 4'h0, rdat, rerr);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, err});
  endtask
  task automatic samp(input logic [31:0] g, x, y, z);
    @(posedge sys_clk_i);
    upd <= 1'b1;
    raw <= '{g, x, y, z};
    @(posedge sys_clk_i);
    upd <= 1'b0;
    @(negedge sys_clk_i);
    chk({31'h0, cvalid}, 32'h0000_0001);
  endtask
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rdc(adr(i), 32'h0000_0000, 1'b0);
      chk(32'(fl_img[16*i +: 16]), 32'h0000_0000);
    end
  endtask
  task automatic t_rw;
    for (int i = 0; i < 7; i++) wr(adr(i), pat(i), 4'hf);
    wr(adr(0), 16'h0000, 4'h0);
    wr(12'h124, 16'h0000, 4'hf);
    @(posedge sys_clk_i);
    for (int i = 0; i < 7; i++) begin
      rdc(adr(i), {16'h0000, pat(i)}, 1'b0);
      chk(32'(fl_img[16*i +: 16]), 32'(pat(i)));
    end
    rdc(12'h124, 32'h0000_0000, 1'b1);
    rdc(12'h520, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_sum;
    az_hi <= 16'h0002;
    az_we <= 1'b1;
    @(posedge sys_clk_i);
    az_we <= 1'b0;
    samp(32'h1234_5678, 32'h0000_0010, 32'hffff_ffff, 32'h0001_0000);
    chk(corr[0], 32'h1234_5678 + {pat(1), pat(0)});
    chk(corr[1], 32'h0000_0010 + {pat(3), pat(2)});
    chk(corr[2], 32'hffff_ffff + {pat(5), pat(4)});
    chk(corr[3], 32'h0001_0000 + {16'h0002, pat(6)});
  endtask
  task automatic t_half;
    wr(adr(1), 16'h0005, 4'hf);
    wr(adr(2), 16'h0000, 4'hf);
    wr(adr(3), 16'hfffe, 4'hf);
    rdc(12'h160, 32'h0000_0003, 1'b0);
    samp(32'h0000_0000, 32'h0003_0000, 32'h0000_0000, 32'h0000_0000);
    chk(corr[0], {pat(1), pat(0)});
    chk(corr[1], 32'h0001_0000);
    wr(adr(0), 16'h0000, 4'hf);
    samp(32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    chk(corr[0], 32'h0005_0001);
    wr(adr(5), 16'h0007, 4'hf);
    samp(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    chk(corr[2], {pat(5), pat(4)});
    samp(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    chk(corr[2], {16'h0007, pat(4)});
  endtask
  task automatic t_flash;
    for (int i = 0; i < 7; i++) fl_data[16*i +: 16] <= 16'ha5a0 + 16'(i);
    fl_ld <= 1'b1;
    @(posedge sys_clk_i);
    fl_ld <= 1'b0;
    for (int i = 0; i < 7; i++) rdc(adr(i), 32'h0000_a5a0 + i, 1'b0);
    samp(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    chk(corr[0], 32'ha5a1_a5a0);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst_n_i = 1'b0;
    fl_ld = 1'b0;
    fl_data = '0;
    az_hi = '0;
    az_we = 1'b0;
    upd = 1'b0;
    raw = '{default: '0};
    mismatches = 0;
    checks = 0;
    do_reset;
    t_reset;
    t_rw;
    t_sum;
    t_half;
    t_flash;
    do_reset;
    t_reset;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    end_sim;
  end
endmodule // tb_top

`default_nettype wire

// *** shared/ibcr_pkg.sv ***
package ibcr_pkg;

  // ==========================================================
  // Widths and counts
  localparam int unsigned IBCR_WORD_W = 16;
  localparam int unsigned IBCR_OFS_W = 32;
  localparam int unsigned IBCR_NUM_WORDS = 7;
  localparam int unsigned IBCR_NUM_AXES = 4;
  localparam int unsigned IBCR_ADDR_W = 12;
  localparam int unsigned IBCR_DATA_W = 32;
  localparam int unsigned IBCR_STRB_W = 4;
  localparam int unsigned IBCR_IDX_W = 8;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] IBCR_IDX_GYRO_Z_BIAS_LOW = 8'h48;
  localparam logic [7:0] IBCR_IDX_GYRO_Z_BIAS_HIGH = 8'h4a;
  localparam logic [7:0] IBCR_IDX_ACCEL_X_BIAS_LOW = 8'h4c;
  localparam logic [7:0] IBCR_IDX_ACCEL_X_BIAS_HIGH = 8'h4e;
  localparam logic [7:0] IBCR_IDX_ACCEL_Y_BIAS_LOW = 8'h50;
  localparam logic [7:0] IBCR_IDX_ACCEL_Y_BIAS_HIGH = 8'h52;
  localparam logic [7:0] IBCR_IDX_ACCEL_Z_BIAS_LOW = 8'h54;
  localparam logic [7:0] IBCR_IDX_PAIR_STATUS = 8'h58;
  localparam logic [7:0] IBCR_IDX_FIRST = IBCR_IDX_GYRO_Z_BIAS_LOW;
  localparam logic [7:0] IBCR_IDX_LAST = IBCR_IDX_ACCEL_Z_BIAS_LOW;
  localparam int unsigned IBCR_IDX_LSB = 2;

  // ==========================================================
  // Axis slots, one per corrected axis
  localparam int unsigned IBCR_AXIS_GYRO_Z = 0;
  localparam int unsigned IBCR_AXIS_ACCEL_X = 1;
  localparam int unsigned IBCR_AXIS_ACCEL_Y = 2;
  localparam int unsigned IBCR_AXIS_ACCEL_Z = 3;

  // ==========================================================
  // Reset values and timing counts
  localparam logic [15:0] IBCR_BIAS_RST = 16'h0000;
  localparam logic [31:0] IBCR_OFS_RST = 32'h0000_0000;
  localparam int unsigned IBCR_STALE_UPDATES = 4;

endpackage

// *** verilog/ibcr_axis_corr.sv ***
`timescale 1ns/1ns
`default_nettype none

module ibcr_axis_corr #(
  parameter int unsigned STALE_UPDATES = ibcr_pkg::IBCR_STALE_UPDATES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Bias words and their write strobes
  input wire logic [ibcr_pkg::IBCR_WORD_W-1:0] low_word_i,
  input wire logic [ibcr_pkg::IBCR_WORD_W-1:0] high_word_i,
  input wire logic low_we_i,
  input wire logic high_we_i,
  // Sensor sample path
  input wire logic update_i,
  input wire logic [ibcr_pkg::IBCR_OFS_W-1:0] raw_i,
  output logic [ibcr_pkg::IBCR_OFS_W-1:0] corr_o,
  output logic [ibcr_pkg::IBCR_OFS_W-1:0] offset_o,
  output logic pending_o
);
  import ibcr_pkg::*;

  logic lo_seen_q, lo_seen_d;
  logic hi_seen_q, hi_seen_d;
  logic [7:0] stale_q, stale_d;
  logic [IBCR_OFS_W-1:0] offset_q, offset_d;
  logic [IBCR_OFS_W-1:0] corr_q, corr_d;
  logic half;
  logic apply;
  logic [IBCR_OFS_W-1:0] eff;

  // ==========================================================
  // Offset commit at sample update
  always_comb begin
    half = lo_seen_q ^ hi_seen_q;
    apply = update_i && (!half || (stale_q >= 8'(STALE_UPDATES - 1)));
    eff = apply ? {high_word_i, low_word_i} : offset_q;
    offset_d = eff;
    lo_seen_d = apply ? low_we_i : (lo_seen_q | low_we_i);
    hi_seen_d = apply ? high_we_i : (hi_seen_q | high_we_i);
    stale_d = stale_q;
    if (apply) begin
      stale_d = 8'h00;
    end else if (update_i && half) begin
      stale_d = stale_q + 8'h01;
    end
    corr_d = corr_q;
    if (update_i) begin
      corr_d = raw_i + eff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_seen_q <= 1'b0;
      hi_seen_q <= 1'b0;
      stale_q <= 8'h00;
      offset_q <= IBCR_OFS_RST;
      corr_q <= IBCR_OFS_RST;
    end else begin
      lo_seen_q <= lo_seen_d;
      hi_seen_q <= hi_seen_d;
      stale_q <= stale_d;
      offset_q <= offset_d;
      corr_q <= corr_d;
    end
  end

  assign corr_o = corr_q;
  assign offset_o = offset_q;
  assign pending_o = lo_seen_q | hi_seen_q;

endmodule // ibcr_axis_corr

`default_nettype wire

// *** verilog/ibcr_bias_regs.sv ***
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none


module ibcr_bias_regs #(
  parameter int unsigned STALE_UPDATES = ibcr_pkg::IBCR_STALE_UPDATES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ibcr_pkg::IBCR_ADDR_W-1:0] paddr_i,
  input wire logic [ibcr_pkg::IBCR_DATA_W-1:0] pwdata_i,
  input wire logic [ibcr_pkg::IBCR_STRB_W-1:0] pstrb_i,
  output logic [ibcr_pkg::IBCR_DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Flash backup and restore
  input wire logic flash_load_i,
  input wire logic [ibcr_pkg::IBCR_NUM_WORDS*ibcr_pkg::IBCR_WORD_W-1:0] flash_load_data_i,
  output logic [ibcr_pkg::IBCR_NUM_WORDS*ibcr_pkg::IBCR_WORD_W-1:0] flash_image_o,
  // Z accel upper word kept elsewhere
  input wire logic [ibcr_pkg::IBCR_WORD_W-1:0] accel_z_bias_high_word_i,
  input wire logic accel_z_bias_high_we_i,
  // Sensor samples
  input wire logic sample_update_i,
  input wire logic [ibcr_pkg::IBCR_OFS_W-1:0] gyro_z_raw_i,
  input wire logic [ibcr_pkg::IBCR_OFS_W-1:0] accel_x_raw_i,
  input wire logic [ibcr_pkg::IBCR_OFS_W-1:0] accel_y_raw_i,
  input wire logic [ibcr_pkg::IBCR_OFS_W-1:0] accel_z_raw_i,
  // Corrected samples
  output logic [ibcr_pkg::IBCR_OFS_W-1:0] gyro_z_corr_o,
  output logic [ibcr_pkg::IBCR_OFS_W-1:0] accel_x_corr_o,
  output logic [ibcr_pkg::IBCR_OFS_W-1:0] accel_y_corr_o,
  output logic [ibcr_pkg::IBCR_OFS_W-1:0] accel_z_corr_o,
  output logic corr_valid_o
);
  import ibcr_pkg::*;

  // ==========================================================
  // Address decode
  function automatic logic [3:0] ibcr_decode(input logic [IBCR_ADDR_W-1:0] addr);
    logic [IBCR_IDX_W-1:0] idx;
    logic [IBCR_IDX_W-1:0] rel;
    idx = addr[IBCR_IDX_LSB +: IBCR_IDX_W];
    rel = idx - IBCR_IDX_FIRST;
    ibcr_decode = 4'h0;
    if ((addr[IBCR_IDX_LSB-1:0] == 2'h0) && (addr[IBCR_ADDR_W-1:IBCR_ADDR_W-2] == 2'h0)) begin
      if ((idx >= IBCR_IDX_FIRST) && (idx <= IBCR_IDX_LAST) && !idx[0]) begin
        ibcr_decode = {1'b1, rel[3:1]};
      end
    end
  endfunction

  function automatic logic ibcr_is_status(input logic [IBCR_ADDR_W-1:0] addr);
    ibcr_is_status = (addr == {2'h0, IBCR_IDX_PAIR_STATUS, 2'h0});
  endfunction

  logic [3:0] dec;
  logic hit_word;
  logic hit_stat;

  always_comb begin
    dec = ibcr_decode(paddr_i);
    hit_word = dec[3];
    hit_stat = ibcr_is_status(paddr_i);
  end

  // ==========================================================
  // APB response
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [IBCR_DATA_W-1:0] prdata_q, prdata_d;
  logic [IBCR_WORD_W-1:0] bias_q [IBCR_NUM_WORDS];
  logic [IBCR_WORD_W-1:0] bias_d [IBCR_NUM_WORDS];
  logic [IBCR_NUM_WORDS-1:0] word_we;
  logic [IBCR_NUM_AXES-1:0] pending;
  logic wr_commit;

  always_comb begin
    pready_d = psel_i && penable_i && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = '0;
    if (pready_d) begin
      pslverr_d = !(hit_word || hit_stat);
      if (!pwrite_i && hit_word) begin
        prdata_d = {16'h0000, bias_q[dec[2:0]]};
      end else if (!pwrite_i && hit_stat) begin
        prdata_d = {28'h0000000, pending};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign prdata_o = prdata_q;

  // ==========================================================
  // Bias word storage
  always_comb begin
    wr_commit = psel_i && penable_i && pready_q && pwrite_i && hit_word;
    for (int i = 0; i < IBCR_NUM_WORDS; i++) begin
      bias_d[i] = bias_q[i];
      word_we[i] = 1'b0;
      if (flash_load_i) begin
        bias_d[i] = flash_load_data_i[i*IBCR_WORD_W +: IBCR_WORD_W];
        word_we[i] = 1'b1;
      end
      if (wr_commit && (dec[2:0] == 3'(i)) && (pstrb_i[1:0] != 2'h0)) begin
        word_we[i] = 1'b1;
        if (pstrb_i[0]) begin
          bias_d[i][7:0] = pwdata_i[7:0];
        end
        if (pstrb_i[1]) begin
          bias_d[i][15:8] = pwdata_i[15:8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < IBCR_NUM_WORDS; i++) begin
        bias_q[i] <= IBCR_BIAS_RST;
      end
    end else begin
      for (int i = 0; i < IBCR_NUM_WORDS; i++) begin
        bias_q[i] <= bias_d[i];
      end
    end
  end

  // ==========================================================
  // Flash image, one word per slot
  logic [IBCR_NUM_WORDS*IBCR_WORD_W-1:0] image_q, image_d;

  always_comb begin
    for (int i = 0; i < IBCR_NUM_WORDS; i++) begin
      image_d[i*IBCR_WORD_W +: IBCR_WORD_W] = bias_d[i];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      image_q <= '0;
    end else begin
      image_q <= image_d;
    end
  end

  assign flash_image_o = image_q;

  // ==========================================================
  // Per axis offset application
  logic [IBCR_WORD_W-1:0] ax_lo [IBCR_NUM_AXES];
  logic [IBCR_WORD_W-1:0] ax_hi [IBCR_NUM_AXES];
  logic [IBCR_NUM_AXES-1:0] ax_lo_we;
  logic [IBCR_NUM_AXES-1:0] ax_hi_we;
  logic [IBCR_OFS_W-1:0] ax_raw [IBCR_NUM_AXES];
  logic [IBCR_OFS_W-1:0] ax_corr [IBCR_NUM_AXES];
  logic [IBCR_OFS_W-1:0] ax_ofs [IBCR_NUM_AXES];

  always_comb begin
    for (int k = 0; k < IBCR_NUM_AXES - 1; k++) begin
      ax_lo[k] = bias_q[2*k];
      ax_hi[k] = bias_q[2*k+1];
      ax_lo_we[k] = word_we[2*k];
      ax_hi_we[k] = word_we[2*k+1];
    end
    ax_lo[IBCR_AXIS_ACCEL_Z] = bias_q[IBCR_NUM_WORDS-1];
    ax_hi[IBCR_AXIS_ACCEL_Z] = accel_z_bias_high_word_i;
    ax_lo_we[IBCR_AXIS_ACCEL_Z] = word_we[IBCR_NUM_WORDS-1];
    ax_hi_we[IBCR_AXIS_ACCEL_Z] = accel_z_bias_high_we_i;
    ax_raw[IBCR_AXIS_GYRO_Z] = gyro_z_raw_i;
    ax_raw[IBCR_AXIS_ACCEL_X] = accel_x_raw_i;
    ax_raw[IBCR_AXIS_ACCEL_Y] = accel_y_raw_i;
    ax_raw[IBCR_AXIS_ACCEL_Z] = accel_z_raw_i;
  end

  for (genvar k = 0; k < IBCR_NUM_AXES; k++) begin : g_axis
    ibcr_axis_corr #(
      .STALE_UPDATES(STALE_UPDATES)
    ) u_corr (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .low_word_i(ax_lo[k]),
      .high_word_i(ax_hi[k]),
      .low_we_i(ax_lo_we[k]),
      .high_we_i(ax_hi_we[k]),
      .update_i(sample_update_i),
      .raw_i(ax_raw[k]),
      .corr_o(ax_corr[k]),
      .offset_o(ax_ofs[k]),
      .pending_o(pending[k])
    );
  end

  logic valid_q, valid_d;

  always_comb begin
    valid_d = sample_update_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  assign corr_valid_o = valid_q;
  assign gyro_z_corr_o = ax_corr[IBCR_AXIS_GYRO_Z];
  assign accel_x_corr_o = ax_corr[IBCR_AXIS_ACCEL_X];
  assign accel_y_corr_o = ax_corr[IBCR_AXIS_ACCEL_Y];
  assign accel_z_corr_o = ax_corr[IBCR_AXIS_ACCEL_Z];

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_access_wait;
    psel_i && penable_i && !pready_o;
  endsequence

  sequence s_bad_access;
    psel_i && penable_i && !pready_o && !hit_word && !hit_stat;
  endsequence

  ready_one_cycle_a: assert property (pready_o |=> !pready_o)
    else $error("pready held for more than one cycle");

  ready_after_wait_a: assert property (s_access_wait |=> pready_o)
    else $error("access phase not answered in one cycle");

  bad_addr_err_a: assert property (s_bad_access |=> (pready_o && pslverr_o && prdata_o == '0))
    else $error("unmapped access not flagged");

  write_lands_a: assert property ((wr_commit && pstrb_i[1:0] == 2'h3 && !flash_load_i)
    |=> bias_q[$past(dec[2:0])] == $past(pwdata_i[15:0]))
    else $error("bias word write lost");

  read_upper_zero_a: assert property ((pready_o && !pslverr_o && $past(!pwrite_i && hit_word))
    |-> prdata_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  gyro_z_sum_a: assert property (corr_valid_o |-> gyro_z_corr_o ==
    32'($past(gyro_z_raw_i) + ax_ofs[IBCR_AXIS_GYRO_Z]))
    else $error("gyro z correction wrong");

  accel_x_sum_a: assert property (corr_valid_o |-> accel_x_corr_o ==
    32'($past(accel_x_raw_i) + ax_ofs[IBCR_AXIS_ACCEL_X]))
    else $error("accel x correction wrong");

  accel_y_sum_a: assert property (corr_valid_o |-> accel_y_corr_o ==
    32'($past(accel_y_raw_i) + ax_ofs[IBCR_AXIS_ACCEL_Y]))
    else $error("accel y correction wrong");

  accel_z_low_a: assert property ($changed(ax_ofs[IBCR_AXIS_ACCEL_Z])
    |-> ax_ofs[IBCR_AXIS_ACCEL_Z][15:0] == $past(bias_q[IBCR_NUM_WORDS-1]))
    else $error("z accel low half not from low word");

  pair_join_a: assert property ($changed(ax_ofs[IBCR_AXIS_ACCEL_X])
    |-> ax_ofs[IBCR_AXIS_ACCEL_X] == {$past(bias_q[3]), $past(bias_q[2])})
    else $error("x accel pair joined wrongly");

  high_word_top_a: assert property ($changed(ax_ofs[IBCR_AXIS_ACCEL_Y])
    |-> ax_ofs[IBCR_AXIS_ACCEL_Y][31:16] == $past(bias_q[5]))
    else $error("y accel high word misplaced");

  commit_on_update_a: assert property ($changed(ax_ofs[IBCR_AXIS_GYRO_Z])
    |-> $past(sample_update_i))
    else $error("offset changed outside a sample update");

endmodule // ibcr_bias_regs

`default_nettype wire
